// ==== hw/uhp_device.sv ====
`timescale 1ns/1ps
module uhp_device #(
	parameter int DW = uhp_pkg::DW
) (
	input  wire logic sys_clk,
	input  wire logic rst,
	uhp_if.dev        lnk
);
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP}
		uhp_rx_st_t;
	typedef struct packed {
		logic [1:0]    rd_s;
		logic [1:0]    wr_s;
		logic          rd_d;
		logic          wr_d;
		logic [1:0]    ser_s;
		logic [1:0]    rck_s;
		logic          rck_d;
		logic          cs_a;
		logic          cs_b;
		logic          cs_n;
		logic [2:0]    sel;
		logic [7:0]    ien;
		logic [7:0]    lctl;
		logic [15:0]   div;
		logic [15:0]   bcnt;
		logic [DW-1:0] thr;
		logic          thr_full;
		logic [DW-1:0] rbuf;
		logic          avail;
		logic          ovr;
		logic          perr;
		logic          ferr;
		uhp_rx_st_t    rx_st;
		logic [3:0]    rsub;
		logic [2:0]    ridx;
		logic [DW-1:0] rsh;
		logic [DW-1:0] dout;
		logic          doe;
		logic          bus_drive_disable_n_n;
		logic          csel;
		logic          baud;
		logic          sout;
		logic          irq;
	} uhp_dev_t;

	uhp_dev_t      s_r;
	uhp_dev_t      s_nxt;
	logic          tx_line;
	logic          tx_busy;
	logic          tx_start;
	logic          btick;
	logic          rtick;
	logic          rx_line;
	logic          sel_ok;
	logic          rd_go;
	logic          wr_go;
	logic [15:0]   div_eff;
	logic [DW-1:0] stat;

	uhp_tx_frame #(.DW(DW)) u_tx (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.tick     (btick),
		.start    (tx_start),
		.data     (s_r.thr),
		.par_en   (s_r.lctl[uhp_pkg::LC_PAR_EN]),
		.par_even (s_r.lctl[uhp_pkg::LC_PAR_EVEN]),
		.two_stop (s_r.lctl[uhp_pkg::LC_TWO_STOP]),
		.line     (tx_line),
		.busy     (tx_busy)
	);

	always_comb begin
		s_nxt = s_r;
		// both strobe polarities merged, then two flops and an edge
		s_nxt.rd_s  = {s_r.rd_s[0], ~lnk.read_strobe_n | lnk.read_strobe_p};
		s_nxt.wr_s  = {s_r.wr_s[0], ~lnk.write_strobe_n | lnk.write_strobe_p};
		s_nxt.rd_d  = s_r.rd_s[1];
		s_nxt.wr_d  = s_r.wr_s[1];
		s_nxt.ser_s = {s_r.ser_s[0], lnk.serial_in};
		s_nxt.rck_s = {s_r.rck_s[0], lnk.rx_clk_in};
		s_nxt.rck_d = s_r.rck_s[1];
		if (!lnk.addr_latch_strobe_n) begin
			s_nxt.cs_a = lnk.select_high_a;
			s_nxt.cs_b = lnk.select_high_b;
			s_nxt.cs_n = lnk.select_low_n;
			s_nxt.sel  = {lnk.reg_sel_2, lnk.reg_sel_1, lnk.reg_sel_0};
		end
		sel_ok = s_r.cs_a & s_r.cs_b & ~s_r.cs_n;
		rd_go  = s_r.rd_s[1] & ~s_r.rd_d & sel_ok;
		wr_go  = s_r.wr_s[1] & ~s_r.wr_d & sel_ok;

		// baud generator: one tick per divisor count of the oscillator
		div_eff = (s_r.div == 16'h0000) ? 16'h0001 : s_r.div;
		btick   = (s_r.bcnt == 16'h0000);
		s_nxt.bcnt = btick ? div_eff - 16'h0001 : s_r.bcnt - 16'h0001;
		s_nxt.baud = (s_nxt.bcnt >= (div_eff >> 1));

		tx_start = s_r.thr_full & ~tx_busy & s_r.lctl[uhp_pkg::LC_TX_EN];
		if (tx_start) begin
			s_nxt.thr_full = 1'b0;
		end

		stat = '0;
		stat[uhp_pkg::LS_AVAIL]   = s_r.avail;
		stat[uhp_pkg::LS_OVR]     = s_r.ovr;
		stat[uhp_pkg::LS_PERR]    = s_r.perr;
		stat[uhp_pkg::LS_FERR]    = s_r.ferr;
		stat[uhp_pkg::LS_THR_MT]  = ~s_r.thr_full;
		stat[uhp_pkg::LS_TX_IDLE] = ~s_r.thr_full & ~tx_busy;

		if (wr_go) begin
			unique case (s_r.sel)
				uhp_pkg::REG_DATA: begin
					// a write into a full holding register is dropped
					if (!s_r.thr_full) begin
						s_nxt.thr      = lnk.host_data_bus;
						s_nxt.thr_full = 1'b1;
					end
				end
				uhp_pkg::REG_IEN:    s_nxt.ien = lnk.host_data_bus;
				uhp_pkg::REG_LCTL:   s_nxt.lctl = lnk.host_data_bus;
				// restart the divider so a new divisor shows at once
				uhp_pkg::REG_DIV_LO: begin
					s_nxt.div[7:0] = lnk.host_data_bus;
					s_nxt.bcnt     = '0;
				end
				uhp_pkg::REG_DIV_HI: begin
					s_nxt.div[15:8] = lnk.host_data_bus;
					s_nxt.bcnt      = '0;
				end
				default: ;
			endcase
		end
		if (rd_go) begin
			unique case (s_r.sel)
				uhp_pkg::REG_DATA: begin
					s_nxt.dout  = s_r.rbuf;
					s_nxt.avail = 1'b0;
				end
				uhp_pkg::REG_IEN:    s_nxt.dout = s_r.ien;
				uhp_pkg::REG_LCTL:   s_nxt.dout = s_r.lctl;
				uhp_pkg::REG_LSTAT: begin
					s_nxt.dout = stat;
					s_nxt.ovr  = 1'b0;
					s_nxt.perr = 1'b0;
					s_nxt.ferr = 1'b0;
				end
				uhp_pkg::REG_DIV_LO: s_nxt.dout = s_r.div[7:0];
				uhp_pkg::REG_DIV_HI: s_nxt.dout = s_r.div[15:8];
				default:             s_nxt.dout = '0;
			endcase
		end

		// receiver: ticks come from the receiver clock pin only
		rtick   = s_r.rck_s[1] & ~s_r.rck_d;
		rx_line = s_r.lctl[uhp_pkg::LC_LOOP] ? tx_line : s_r.ser_s[1];
		if (rtick) begin
			s_nxt.rsub = s_r.rsub + 4'h1;
			unique case (s_r.rx_st)
				RX_IDLE: begin
					s_nxt.rsub = '0;
					if (!rx_line) begin
						s_nxt.rx_st = RX_START;
					end
				end
				RX_START: begin
					if (s_r.rsub == uhp_pkg::SUB_MID) begin
						s_nxt.rsub  = '0;
						s_nxt.ridx  = '0;
						s_nxt.rx_st = rx_line ? RX_IDLE : RX_DATA;
					end
				end
				RX_DATA: begin
					if (s_r.rsub == uhp_pkg::SUB_LAST) begin
						s_nxt.rsh  = {rx_line, s_r.rsh[DW-1:1]};
						s_nxt.ridx = s_r.ridx + 3'h1;
						if (s_r.ridx == uhp_pkg::BIT_LAST) begin
							s_nxt.rx_st = s_r.lctl[uhp_pkg::LC_PAR_EN] ?
								RX_PAR : RX_STOP;
						end
					end
				end
				RX_PAR: begin
					if (s_r.rsub == uhp_pkg::SUB_LAST) begin
						s_nxt.rx_st = RX_STOP;
						if (rx_line != (s_r.lctl[uhp_pkg::LC_PAR_EVEN] ?
							^s_r.rsh : ~(^s_r.rsh))) begin
							s_nxt.perr = 1'b1;
						end
					end
				end
				default: begin
					if (s_r.rsub == uhp_pkg::SUB_LAST) begin
						// new character beats a same-cycle read clear
						s_nxt.rx_st = RX_IDLE;
						s_nxt.rbuf  = s_r.rsh;
						s_nxt.avail = 1'b1;
						if (s_r.avail) begin
							s_nxt.ovr = 1'b1;
						end
						if (!rx_line) begin
							s_nxt.ferr = 1'b1;
						end
					end
				end
			endcase
		end

		s_nxt.doe    = s_r.rd_s[1] & sel_ok;
		s_nxt.bus_drive_disable_n_n = ~(s_r.rd_s[1] & sel_ok);
		s_nxt.csel   = sel_ok;
		s_nxt.sout   = (s_r.lctl[uhp_pkg::LC_TX_EN] &
			~s_r.lctl[uhp_pkg::LC_LOOP]) ? tx_line : 1'b1;
		s_nxt.irq    = (s_r.ien[uhp_pkg::IE_RX] & s_r.avail) |
			(s_r.ien[uhp_pkg::IE_TX] & ~s_r.thr_full) |
			(s_r.ien[uhp_pkg::IE_ERR] & (s_r.ovr | s_r.perr | s_r.ferr));
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s_r        <= '0;
			s_r.lctl   <= uhp_pkg::LCTL_RST;
			s_r.ien    <= uhp_pkg::IEN_RST;
			s_r.div    <= uhp_pkg::DIV_RST;
			s_r.ser_s  <= 2'b11;
			s_r.bus_drive_disable_n_n <= 1'b1;
			s_r.sout   <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign lnk.dev_data_out        = s_r.dout;
	assign lnk.dev_data_oe         = s_r.doe;
	assign lnk.bus_drive_disable_n = s_r.bus_drive_disable_n_n;
	assign lnk.selected_indication = s_r.csel;
	assign lnk.irq                 = s_r.irq;
	assign lnk.baud_x16_clock_out  = s_r.baud;
	assign lnk.serial_out          = s_r.sout;
endmodule : uhp_device

// ==== hw/uhp_pkg.sv ====
package uhp_pkg;
	localparam int          DW          = 8;
	localparam int          AW          = 3;
	localparam int          CLK_NS      = 10;
	// register indices chosen by the select lines
	localparam logic [2:0]  REG_DATA    = 3'h0;
	localparam logic [2:0]  REG_IEN     = 3'h1;
	localparam logic [2:0]  REG_LCTL    = 3'h2;
	localparam logic [2:0]  REG_LSTAT   = 3'h3;
	localparam logic [2:0]  REG_DIV_LO  = 3'h4;
	localparam logic [2:0]  REG_DIV_HI  = 3'h5;
	// line control bits
	localparam int          LC_PAR_EN   = 0;
	localparam int          LC_PAR_EVEN = 1;
	localparam int          LC_TWO_STOP = 2;
	localparam int          LC_TX_EN    = 3;
	localparam int          LC_LOOP     = 4;
	// interrupt enable bits
	localparam int          IE_RX       = 0;
	localparam int          IE_TX       = 1;
	localparam int          IE_ERR      = 2;
	// line status bits
	localparam int          LS_AVAIL    = 0;
	localparam int          LS_OVR      = 1;
	localparam int          LS_PERR     = 2;
	localparam int          LS_FERR     = 3;
	localparam int          LS_THR_MT   = 4;
	localparam int          LS_TX_IDLE  = 5;
	localparam logic [7:0]  LCTL_RST    = 8'h00;
	localparam logic [7:0]  IEN_RST     = 8'h00;
	localparam logic [15:0] DIV_RST     = 16'h0000;
	// oversampling: sixteen ticks per bit, start checked mid-bit
	localparam logic [3:0]  SUB_LAST    = 4'hf;
	localparam logic [3:0]  SUB_MID     = 4'h7;
	localparam logic [2:0]  BIT_LAST    = 3'h7;
	// host access timing
	localparam int          STROBE_NS   = 50;
	localparam int          HOLD_NS     = 40;
	localparam int          STROBE_CYC  = (STROBE_NS + CLK_NS - 1) / CLK_NS;
	localparam int          HOLD_CYC    = (HOLD_NS + CLK_NS - 1) / CLK_NS;
endpackage : uhp_pkg

// ==== hw/uhp_if.sv ====
`timescale 1ns/1ps
interface uhp_if;
	logic [7:0] host_data_out;
	logic       host_data_oe;
	logic [7:0] dev_data_out;
	logic       dev_data_oe;
	logic [7:0] host_data_bus;
	logic       select_high_a;
	logic       select_high_b;
	logic       select_low_n;
	logic       write_strobe_n;
	logic       write_strobe_p;
	logic       read_strobe_n;
	logic       read_strobe_p;
	logic       addr_latch_strobe_n;
	logic       reg_sel_2;
	logic       reg_sel_1;
	logic       reg_sel_0;
	logic       bus_drive_disable_n;
	logic       selected_indication;
	logic       irq;
	logic       baud_x16_clock_out;
	logic       serial_out;
	logic       serial_in;
	logic       rx_clk_in;

	// undriven bus floats high through the pull-ups
	assign host_data_bus = dev_data_oe ? dev_data_out :
		host_data_oe ? host_data_out : 8'hff;

	modport dev (
		input  host_data_bus, select_high_a, select_high_b, select_low_n,
		input  write_strobe_n, write_strobe_p, read_strobe_n, read_strobe_p,
		input  addr_latch_strobe_n, reg_sel_2, reg_sel_1, reg_sel_0,
		input  serial_in, rx_clk_in,
		output dev_data_out, dev_data_oe, bus_drive_disable_n,
		output selected_indication, irq, baud_x16_clock_out, serial_out
	);
	modport host (
		input  host_data_bus, bus_drive_disable_n, selected_indication, irq,
		input  baud_x16_clock_out, serial_out,
		output host_data_out, host_data_oe, select_high_a, select_high_b,
		output select_low_n, write_strobe_n, write_strobe_p, read_strobe_n,
		output read_strobe_p, addr_latch_strobe_n, reg_sel_2, reg_sel_1,
		output reg_sel_0, serial_in, rx_clk_in
	);
endinterface : uhp_if

// ==== hw/uhp_tx_frame.sv ====
`timescale 1ns/1ps
module uhp_tx_frame #(
	parameter int DW = uhp_pkg::DW
) (
	input  wire logic          sys_clk,
	input  wire logic          rst,
	input  wire logic          tick,
	input  wire logic          start,
	input  wire logic [DW-1:0] data,
	input  wire logic          par_en,
	input  wire logic          par_even,
	input  wire logic          two_stop,
	output logic               line,
	output logic               busy
);
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP}
		uhp_tx_st_t;
	typedef struct packed {
		uhp_tx_st_t    st;
		logic [3:0]    sub;
		logic [2:0]    idx;
		logic [DW-1:0] sh;
		logic          pbit;
		logic          pen;
		logic          stop2;
		logic          second;
		logic          line;
		logic          busy;
	} uhp_tx_t;

	uhp_tx_t s_r;
	uhp_tx_t s_nxt;

	always_comb begin
		s_nxt = s_r;
		unique case (s_r.st)
			TX_IDLE: begin
				if (start) begin
					s_nxt.st     = TX_START;
					s_nxt.sh     = data;
					s_nxt.pbit   = par_even ? ^data : ~(^data);
					s_nxt.pen    = par_en;
					s_nxt.stop2  = two_stop;
					s_nxt.second = 1'b0;
					s_nxt.sub    = '0;
					s_nxt.idx    = '0;
					s_nxt.line   = 1'b0;
					s_nxt.busy   = 1'b1;
				end
			end
			default: begin
				if (tick) begin
					s_nxt.sub = s_r.sub + 4'h1;
				end
				if (tick && s_r.sub == uhp_pkg::SUB_LAST) begin
					unique case (s_r.st)
						TX_START: begin
							s_nxt.st   = TX_DATA;
							s_nxt.line = s_r.sh[0];
						end
						TX_DATA: begin
							s_nxt.idx = s_r.idx + 3'h1;
							s_nxt.sh  = s_r.sh >> 1;
							if (s_r.idx == uhp_pkg::BIT_LAST) begin
								s_nxt.st   = s_r.pen ? TX_PAR : TX_STOP;
								s_nxt.line = s_r.pen ? s_r.pbit : 1'b1;
							end else begin
								s_nxt.line = s_r.sh[1];
							end
						end
						TX_PAR: begin
							s_nxt.st   = TX_STOP;
							s_nxt.line = 1'b1;
						end
						default: begin
							if (s_r.stop2 && !s_r.second) begin
								s_nxt.second = 1'b1;
							end else begin
								s_nxt.st   = TX_IDLE;
								s_nxt.busy = 1'b0;
							end
						end
					endcase
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s_r      <= '0;
			s_r.line <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign line = s_r.line;
	assign busy = s_r.busy;
endmodule : uhp_tx_frame

// ==== hw/uhp_host.sv ====
`timescale 1ns/1ps
module uhp_host #(
	parameter int STROBE_CYC = uhp_pkg::STROBE_CYC,
	parameter int HOLD_CYC   = uhp_pkg::HOLD_CYC
) (
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic       cmd_valid,
	input  wire logic       cmd_write,
	input  wire logic [2:0] cmd_addr,
	input  wire logic [7:0] cmd_wdata,
	output logic            cmd_ready,
	output logic            rsp_valid,
	output logic [7:0]      rsp_rdata,
	input  wire logic       line_in,
	output logic            line_out,
	output logic            irq_out,
	input  wire logic       rx_clk_ext_sel,
	input  wire logic       rx_clk_ext,
	uhp_if.host             lnk
);
	typedef enum logic [1:0] {H_IDLE, H_SETUP, H_STROBE, H_HOLD} uhp_h_st_t;
	typedef struct packed {
		uhp_h_st_t  st;
		logic [7:0] cnt;
		logic       wr;
		logic [2:0] addr;
		logic [7:0] dout;
		logic       doe;
		logic       cs;
		logic       wstb_n;
		logic       rstb_n;
		logic       ready;
		logic       rvalid;
		logic [7:0] rdata;
		logic       ser;
		logic       rck;
		logic       lout;
		logic       irq;
	} uhp_host_t;

	uhp_host_t s_r;
	uhp_host_t s_nxt;

	always_comb begin
		s_nxt        = s_r;
		s_nxt.rvalid = 1'b0;
		s_nxt.ser    = line_in;
		// board strap: receiver follows the baud output unless overridden
		s_nxt.rck    = rx_clk_ext_sel ? rx_clk_ext :
			lnk.baud_x16_clock_out;
		s_nxt.lout   = lnk.serial_out;
		s_nxt.irq    = lnk.irq;
		unique case (s_r.st)
			H_IDLE: begin
				if (cmd_valid) begin
					s_nxt.st    = H_SETUP;
					s_nxt.ready = 1'b0;
					s_nxt.wr    = cmd_write;
					s_nxt.addr  = cmd_addr;
					s_nxt.dout  = cmd_wdata;
					s_nxt.doe   = cmd_write;
					s_nxt.cs    = 1'b1;
				end
			end
			H_SETUP: begin
				s_nxt.st     = H_STROBE;
				s_nxt.cnt    = 8'(STROBE_CYC - 1);
				s_nxt.wstb_n = ~s_r.wr;
				s_nxt.rstb_n = s_r.wr;
			end
			H_STROBE: begin
				s_nxt.cnt = s_r.cnt - 8'h01;
				if (s_r.cnt == 8'h00) begin
					s_nxt.st     = H_HOLD;
					s_nxt.cnt    = 8'(HOLD_CYC - 1);
					s_nxt.wstb_n = 1'b1;
					s_nxt.rstb_n = 1'b1;
					s_nxt.doe    = 1'b0;
					s_nxt.cs     = 1'b0;
					s_nxt.rvalid = 1'b1;
					s_nxt.rdata  = s_r.wr ? 8'h00 : lnk.host_data_bus;
				end
			end
			H_HOLD: begin
				s_nxt.cnt = s_r.cnt - 8'h01;
				if (s_r.cnt == 8'h00) begin
					s_nxt.st    = H_IDLE;
					s_nxt.ready = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s_r        <= '0;
			s_r.wstb_n <= 1'b1;
			s_r.rstb_n <= 1'b1;
			s_r.ser    <= 1'b1;
			s_r.lout   <= 1'b1;
			s_r.ready  <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign lnk.host_data_out       = s_r.dout;
	assign lnk.host_data_oe        = s_r.doe;
	assign lnk.select_high_a       = s_r.cs;
	assign lnk.select_high_b       = s_r.cs;
	assign lnk.select_low_n        = ~s_r.cs;
	assign lnk.write_strobe_n      = s_r.wstb_n;
	assign lnk.write_strobe_p      = 1'b0;
	assign lnk.read_strobe_n       = s_r.rstb_n;
	assign lnk.read_strobe_p       = 1'b0;
	assign lnk.addr_latch_strobe_n = 1'b0;
	assign lnk.reg_sel_2           = s_r.addr[2];
	assign lnk.reg_sel_1           = s_r.addr[1];
	assign lnk.reg_sel_0           = s_r.addr[0];
	assign lnk.serial_in           = s_r.ser;
	assign lnk.rx_clk_in           = s_r.rck;
	assign cmd_ready               = s_r.ready;
	assign rsp_valid               = s_r.rvalid;
	assign rsp_rdata               = s_r.rdata;
	assign line_out                = s_r.lout;
	assign irq_out                 = s_r.irq;
endmodule : uhp_host

// ==== verification/uhp_assertions.sv ====
`timescale 1ns/1ps
module uhp_assertions (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic select_high_a,
	input wire logic select_high_b,
	input wire logic select_low_n,
	input wire logic write_strobe_n,
	input wire logic write_strobe_p,
	input wire logic read_strobe_n,
	input wire logic read_strobe_p,
	input wire logic addr_latch_strobe_n,
	input wire logic host_data_oe,
	input wire logic dev_data_oe,
	input wire logic bus_drive_disable_n,
	input wire logic selected_indication,
	input wire logic irq,
	input wire logic serial_out
);
	wire logic sel_on = select_high_a & select_high_b & ~select_low_n;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	sequence s_sel3;
		sel_on [*3];
	endsequence
	sequence s_unsel3;
		!sel_on [*3];
	endsequence
	sequence s_start_low;
		!serial_out [*8];
	endsequence

	property p_rst_idle;
		$past(rst) |-> serial_out && bus_drive_disable_n &&
			!selected_indication && !irq && !dev_data_oe;
	endproperty
	a_rst_idle: assert property (p_rst_idle)
		else $error("outputs not idle after reset");
	property p_sel_on;
		s_sel3 |-> selected_indication;
	endproperty
	a_sel_on: assert property (p_sel_on)
		else $error("select indication missing");
	property p_sel_off;
		s_unsel3 |-> !selected_indication;
	endproperty
	a_sel_off: assert property (p_sel_off)
		else $error("select indication without selects");
	property p_bus_drive_disable_n;
		!bus_drive_disable_n |-> !$past(read_strobe_n, 3);
	endproperty
	a_bus_drive_disable_n: assert property (p_bus_drive_disable_n)
		else $error("drive disable low without read");
	property p_bus_drive_disable_n_rise;
		$fell(read_strobe_n) && sel_on |-> ##3 !bus_drive_disable_n;
	endproperty
	a_bus_drive_disable_n_rise: assert property (p_bus_drive_disable_n_rise)
		else $error("drive disable late for read");
	property p_oe;
		dev_data_oe |-> !$past(read_strobe_n, 3);
	endproperty
	a_oe: assert property (p_oe)
		else $error("device drives bus outside read");
	property p_bus_own;
		!(dev_data_oe && host_data_oe);
	endproperty
	a_bus_own: assert property (p_bus_own)
		else $error("both ends drive data bus");
	property p_start;
		$fell(serial_out) |-> s_start_low;
	endproperty
	a_start: assert property (p_start)
		else $error("start bit too short");
	property p_one_strobe;
		!write_strobe_p && !read_strobe_p &&
			!(!write_strobe_n && !read_strobe_n);
	endproperty
	a_one_strobe: assert property (p_one_strobe)
		else $error("strobe polarity or overlap wrong");
	property p_latch;
		!addr_latch_strobe_n;
	endproperty
	a_latch: assert property (p_latch)
		else $error("address strobe not held low");
endmodule : uhp_assertions

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
	logic       sys_clk;
	logic       rst;
	logic       cmd_valid;
	logic       cmd_write;
	logic [2:0] cmd_addr;
	logic [7:0] cmd_wdata;
	logic       cmd_ready;
	logic       rsp_valid;
	logic [7:0] rsp_rdata;
	logic       line_in;
	logic       line_out;
	logic       irq_out;
	logic       rx_clk_ext_sel;
	logic       rx_clk_ext = 1'b0;
	logic [7:0] rd;
	int         error_cnt = 0;
	int         total_checks = 0;
	int         cyc = 0;

	uhp_if lnk ();
	uhp_device i_uhp_device (.sys_clk(sys_clk), .rst(rst), .lnk(lnk));
	uhp_host i_uhp_host (
		.sys_clk(sys_clk), .rst(rst), .cmd_valid(cmd_valid),
		.cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
		.cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
		.line_in(line_in), .line_out(line_out), .irq_out(irq_out),
		.rx_clk_ext_sel(rx_clk_ext_sel), .rx_clk_ext(rx_clk_ext), .lnk(lnk));
	uhp_assertions i_uhp_assertions (
		.sys_clk(sys_clk), .rst(rst), .select_high_a(lnk.select_high_a),
		.select_high_b(lnk.select_high_b), .select_low_n(lnk.select_low_n),
		.write_strobe_n(lnk.write_strobe_n),
		.write_strobe_p(lnk.write_strobe_p),
		.read_strobe_n(lnk.read_strobe_n), .read_strobe_p(lnk.read_strobe_p),
		.addr_latch_strobe_n(lnk.addr_latch_strobe_n),
		.host_data_oe(lnk.host_data_oe), .dev_data_oe(lnk.dev_data_oe),
		.bus_drive_disable_n(lnk.bus_drive_disable_n),
		.selected_indication(lnk.selected_indication), .irq(lnk.irq),
		.serial_out(lnk.serial_out));

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// receiver clock unrelated to the divisor: one tick every four cycles
	always @(negedge sys_clk) begin
		cyc <= cyc + 1;
		rx_clk_ext <= cyc[1];
	end

	always @(posedge sys_clk) begin
		if (cyc == 20000) begin
			error_cnt++;
			summarize;
		end
	end

	task automatic summarize;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : summarize

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	// one host access; returns once the host is ready for the next one
	task automatic bus(input logic wr, input logic [2:0] a,
		input logic [7:0] d);
		@(negedge sys_clk);
		cmd_valid = 1'b1;
		cmd_write = wr;
		cmd_addr = a;
		cmd_wdata = d;
		@(negedge sys_clk);
		cmd_valid = 1'b0;
		for (int i = 0; i < 20 && !rsp_valid; i++)
			@(negedge sys_clk);
		rd = rsp_rdata;
		for (int i = 0; i < 20 && !cmd_ready; i++)
			@(negedge sys_clk);
	endtask : bus

	task automatic t_reset;
		check({13'h0, lnk.serial_out, lnk.bus_drive_disable_n,
			lnk.selected_indication}, 16'h6);
		bus(1'b0, uhp_pkg::REG_LCTL, 8'h00);
		check({8'h0, rd}, {8'h0, uhp_pkg::LCTL_RST});
		bus(1'b0, uhp_pkg::REG_IEN, 8'h00);
		check({8'h0, rd}, {8'h0, uhp_pkg::IEN_RST});
		bus(1'b0, uhp_pkg::REG_DIV_HI, 8'h00);
		check({8'h0, rd}, {8'h0, uhp_pkg::DIV_RST[15:8]});
	endtask : t_reset

	task automatic t_regs;
		logic [2:0] a[4];
		logic [7:0] v[4];
		logic       p;
		int         n;
		int         lo;
		a = '{uhp_pkg::REG_IEN, uhp_pkg::REG_LCTL, uhp_pkg::REG_DIV_LO,
			uhp_pkg::REG_DIV_HI};
		v = '{8'h04, 8'h07, 8'h02, 8'h5a};
		for (int i = 0; i < 4; i++)
			bus(1'b1, a[i], v[i]);
		for (int i = 0; i < 4; i++) begin
			bus(1'b0, a[i], 8'h00);
			check({8'h0, rd}, {8'h0, v[i]});
		end
		bus(1'b1, 3'h6, 8'hff);
		bus(1'b0, 3'h6, 8'h00);
		check({8'h0, rd}, 16'h0);
		bus(1'b1, uhp_pkg::REG_DIV_HI, 8'h00);
		// divisor 2: one baud rise every two cycles, line idle as tx is off
		n = 0;
		lo = 0;
		p = lnk.baud_x16_clock_out;
		repeat (64) begin
			@(negedge sys_clk);
			n += int'(lnk.baud_x16_clock_out && !p);
			lo += int'(!lnk.serial_out);
			p = lnk.baud_x16_clock_out;
		end
		check(n[15:0], 16'd32);
		check(lo[15:0], 16'h0);
	endtask : t_regs

	task automatic t_loop;
		int lo;
		lo = 0;
		bus(1'b1, uhp_pkg::REG_LCTL, 8'h1f);
		line_in = 1'b0;
		bus(1'b1, uhp_pkg::REG_DATA, 8'ha5);
		repeat (600) begin
			@(negedge sys_clk);
			lo += int'(!lnk.serial_out);
		end
		check(lo[15:0], 16'h0);
		bus(1'b0, uhp_pkg::REG_LSTAT, 8'h00);
		check({8'h0, rd}, 16'h0031);
		bus(1'b0, uhp_pkg::REG_DATA, 8'h00);
		check({8'h0, rd}, 16'h00a5);
		line_in = 1'b1;
		bus(1'b1, uhp_pkg::REG_LCTL, 8'h00);
	endtask : t_loop

	task automatic t_tx;
		logic [11:0] got;
		logic [11:0] want;
		want = {2'b11, ^8'h34, 8'h34, 1'b0};
		bus(1'b1, uhp_pkg::REG_LCTL, 8'h0f);
		bus(1'b1, uhp_pkg::REG_DATA, 8'h34);
		for (int i = 0; i < 300 && lnk.serial_out; i++)
			@(negedge sys_clk);
		repeat (16) @(negedge sys_clk);
		for (int i = 0; i < 12; i++) begin
			got[i] = lnk.serial_out;
			check({15'h0, line_out}, {15'h0, want[i]});
			repeat (32) @(negedge sys_clk);
		end
		check({4'h0, got}, {4'h0, want});
		bus(1'b1, uhp_pkg::REG_LCTL, 8'h00);
	endtask : t_tx

	task automatic t_rx;
		logic [9:0] frame;
		frame = {1'b1, 8'hc6, 1'b0};
		rx_clk_ext_sel = 1'b1;
		bus(1'b1, uhp_pkg::REG_IEN, 8'h01);
		check({15'h0, irq_out}, 16'h0);
		// bits last 64 cycles: right only if the receiver uses its own clock
		for (int i = 0; i < 10; i++) begin
			line_in = frame[i];
			repeat (64) @(negedge sys_clk);
		end
		repeat (40) @(negedge sys_clk);
		check({15'h0, irq_out}, 16'h1);
		bus(1'b0, uhp_pkg::REG_DATA, 8'h00);
		check({8'h0, rd}, 16'h00c6);
		repeat (4) @(negedge sys_clk);
		check({15'h0, irq_out}, 16'h0);
		bus(1'b1, uhp_pkg::REG_IEN, 8'h02);
		check({15'h0, irq_out}, 16'h1);
	endtask : t_rx

	initial begin
		rst = 1'b1;
		cmd_valid = 1'b0;
		cmd_write = 1'b0;
		cmd_addr = 3'h0;
		cmd_wdata = 8'h00;
		line_in = 1'b1;
		rx_clk_ext_sel = 1'b0;
		repeat (8) @(negedge sys_clk);
		rst = 1'b0;
		@(negedge sys_clk);
		t_reset;
		t_regs;
		t_loop;
		t_tx;
		t_rx;
		summarize;
	end
endmodule : tb_top
